/* aos_serial_out.sv */
// Converter output formatting, serial link master and AHB-Lite register slave
`timescale 1ns/100ps
`default_nettype none
module aos_serial_out
    import aos_pkg::*;
(
    // System
    input  wire logic                clk,
    input  wire logic                rstn,
    // Converter side pins
    input  wire logic                conv_clock,
    input  wire logic                align_pulse,
    input  wire logic                power_down_n,
    input  wire logic                internal_reference_select,
    // Decimation filter result, same clock domain
    input  wire logic [RAW_BITS-1:0] filter_result,
    // Reference generator control
    output logic                     ref_gen_enable,
    // Serial link
    output logic                     frame_start_out,
    output logic                     frame_start_out_n,
    output logic                     serial_shift_clock,
    output logic                     serial_shift_clock_n,
    output logic                     serial_data_out,
    output logic                     serial_data_out_n,
    output logic                     overrange_flag,
    // AHB-Lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic [31:0]              hrdata,
    output logic                     hreadyout,
    output logic                     hresp,
    // Interrupt
    output logic                     irq
);

    // Clip a filter result to the word range, flagging overrange
    function automatic logic [16:0] clip_word(input logic [RAW_BITS-1:0] raw);
        logic signed [RAW_BITS-1:0] s;
        s = raw;
        if (s > $signed({{(RAW_BITS-WORD_BITS){1'b0}}, POS_FULL})) begin
            clip_word = {1'b1, POS_FULL};
        end else if (s < $signed({{(RAW_BITS-WORD_BITS){1'b1}}, NEG_FULL})) begin
            clip_word = {1'b1, NEG_FULL};
        end else begin
            clip_word = {1'b0, raw[WORD_BITS-1:0]};
        end
    endfunction

    // Two-stage synchronisers for every pin input
    logic [1:0] conv_sync_reg, align_sync_reg, pd_sync_reg, ref_sync_reg;
    logic       conv_prev_reg, align_prev_reg;

    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            conv_sync_reg  <= 2'h0;
            align_sync_reg <= 2'h0;
            pd_sync_reg    <= 2'h0;
            ref_sync_reg   <= 2'h0;
            conv_prev_reg  <= 1'b0;
            align_prev_reg <= 1'b0;
        end else begin
            conv_sync_reg  <= {conv_sync_reg[0], conv_clock};
            align_sync_reg <= {align_sync_reg[0], align_pulse};
            pd_sync_reg    <= {pd_sync_reg[0], power_down_n};
            ref_sync_reg   <= {ref_sync_reg[0], internal_reference_select};
            conv_prev_reg  <= conv_sync_reg[1];
            align_prev_reg <= align_sync_reg[1];
        end
    end

    // Edge detection on the synchronised levels only
    logic conv_rise, conv_fall, align_fall, powered;
    assign conv_rise  = conv_sync_reg[1] & ~conv_prev_reg;
    assign conv_fall  = ~conv_sync_reg[1] & conv_prev_reg;
    assign align_fall = ~align_sync_reg[1] & align_prev_reg;
    assign powered    = pd_sync_reg[1];

    // Link state
    aos_state_type   state_reg, state_next;
    logic [3:0]      sample_cnt_reg, sample_cnt_next;
    logic [5:0]      settle_cnt_reg, settle_cnt_next;
    logic            align_seen_reg, align_seen_next;
    logic [15:0]     shift_reg, shift_next;
    logic [15:0]     last_word_reg, last_word_next;
    logic            frame_reg, frame_next;
    logic            sclk_reg, sclk_next;
    logic            dout_reg, dout_next;
    logic            over_pend_reg, over_pend_next;
    logic            otr_reg, otr_next;
    logic            ref_en_reg, ref_en_next;
    logic            word_evt, settle_evt, over_evt;
    logic            soft_align;                    // Driven from the bus side
    logic [16:0]     clipped;
    logic            boundary;
    assign clipped  = clip_word(filter_result);
    assign boundary = conv_rise && (sample_cnt_reg == DECIM_LAST);

    // Next values of the link: everything counts converter clock edges
    always_comb begin
        state_next      = state_reg;
        sample_cnt_next = sample_cnt_reg;
        settle_cnt_next = settle_cnt_reg;
        align_seen_next = align_seen_reg;
        shift_next      = shift_reg;
        last_word_next  = last_word_reg;
        frame_next      = frame_reg;
        sclk_next       = sclk_reg;
        dout_next       = dout_reg;
        over_pend_next  = over_pend_reg;
        otr_next        = otr_reg;
        ref_en_next     = ~ref_sync_reg[1];
        word_evt        = 1'b0;
        settle_evt      = 1'b0;
        over_evt        = 1'b0;
        // Shift clock follows the converter clock, one bit per period
        if (conv_rise) begin
            sclk_next = 1'b1;
        end else if (conv_fall) begin
            sclk_next = 1'b0;
            // Overrange moves only here, so receivers see it settle
            otr_next = over_pend_reg;
            over_evt = over_pend_reg & ~otr_reg;
        end
        // Pulse must be seen high at a converter edge to count
        if (align_sync_reg[1] && conv_rise) begin
            align_seen_next = 1'b1;
        end
        if (conv_rise) begin
            sample_cnt_next = sample_cnt_reg + 4'h1;
        end
        case (state_reg)
            LS_UNALIGNED, LS_ALIGNING: begin
                frame_next = 1'b0;
                dout_next  = 1'b0;
                if (align_seen_reg) begin
                    state_next = LS_ALIGNING;
                end
            end
            LS_SETTLING: begin
                frame_next = 1'b0;
                dout_next  = 1'b0;
                if (boundary) begin
                    settle_cnt_next = settle_cnt_reg + 6'h1;
                    if (settle_cnt_reg == SETTLE_WORDS - 6'h1) begin
                        state_next = LS_RUNNING;
                        settle_evt = 1'b1;
                    end
                end
            end
            LS_RUNNING: begin
                if (boundary) begin
                    shift_next     = {clipped[14:0], 1'b0};
                    dout_next      = clipped[15];
                    frame_next     = 1'b1;
                    last_word_next = clipped[15:0];
                    over_pend_next = clipped[16];
                    word_evt       = 1'b1;
                end else if (conv_rise) begin
                    shift_next = {shift_reg[14:0], 1'b0};
                    dout_next  = shift_reg[15];
                    frame_next = 1'b0;
                end
            end
            default: begin
                state_next = LS_UNALIGNED;
            end
        endcase
        // Release of a qualified pulse restarts counters identically
        if ((align_fall && align_seen_reg) || soft_align) begin
            state_next      = LS_SETTLING;
            sample_cnt_next = DECIM_LAST;
            settle_cnt_next = 6'h0;
            align_seen_next = 1'b0;
            frame_next      = 1'b0;
        end
        // Power-down keeps alignment but the filter must settle again
        if (!powered) begin
            if (state_reg != LS_UNALIGNED && state_reg != LS_ALIGNING) begin
                state_next = LS_SETTLING;
            end
            settle_cnt_next = 6'h0;
            frame_next      = 1'b0;
            dout_next       = 1'b0;
            word_evt        = 1'b0;
            settle_evt      = 1'b0;
        end
    end

    // Link registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            state_reg      <= LS_UNALIGNED;
            sample_cnt_reg <= 4'h0;
            settle_cnt_reg <= 6'h0;
            align_seen_reg <= 1'b0;
            shift_reg      <= WORD_RST;
            last_word_reg  <= WORD_RST;
            frame_reg      <= 1'b0;
            sclk_reg       <= 1'b0;
            dout_reg       <= 1'b0;
            over_pend_reg  <= 1'b0;
            otr_reg        <= 1'b0;
            ref_en_reg     <= 1'b1;
        end else begin
            state_reg      <= state_next;
            sample_cnt_reg <= sample_cnt_next;
            settle_cnt_reg <= settle_cnt_next;
            align_seen_reg <= align_seen_next;
            shift_reg      <= shift_next;
            last_word_reg  <= last_word_next;
            frame_reg      <= frame_next;
            sclk_reg       <= sclk_next;
            dout_reg       <= dout_next;
            over_pend_reg  <= over_pend_next;
            otr_reg        <= otr_next;
            ref_en_reg     <= ref_en_next;
        end
    end

    // True link outputs straight from flops, inverted ones through an inverter on the same flops
    assign frame_start_out      = frame_reg;
    assign frame_start_out_n    = ~frame_reg;
    assign serial_shift_clock   = sclk_reg;
    assign serial_shift_clock_n = ~sclk_reg;
    assign serial_data_out      = dout_reg;
    assign serial_data_out_n    = ~dout_reg;
    assign overrange_flag       = otr_reg;
    assign ref_gen_enable       = ref_en_reg;

    // Bus state
    logic                wr_pend_reg, wr_pend_next;
    logic                rd_pend_reg, rd_pend_next;
    logic [7:0]          addr_reg, addr_next;
    logic [31:0]         rdata_reg, rdata_next;
    logic [INT_BITS-1:0] int_stat_reg, int_stat_next;
    logic [INT_BITS-1:0] int_mask_reg, int_mask_next;
    logic                soft_align_reg, soft_align_next;
    logic                take;
    logic [INT_BITS-1:0] int_set;
    assign take    = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == HTRANS_SEQ);
    assign int_set = {settle_evt, over_evt, word_evt};
    assign soft_align = soft_align_reg;
    // Bus next values; reads add one wait state so hrdata comes from a flop
    always_comb begin
        wr_pend_next    = 1'b0;
        rd_pend_next    = 1'b0;
        addr_next       = addr_reg;
        rdata_next      = rdata_reg;
        int_mask_next   = int_mask_reg;
        soft_align_next = 1'b0;
        int_stat_next   = int_stat_reg;
        if (wr_pend_reg) begin
            case (addr_reg)
                OFS_CTRL:     soft_align_next = hwdata[CTRL_SOFT_ALIGN];
                OFS_INT_STAT: int_stat_next   = int_stat_reg & ~hwdata[INT_BITS-1:0];
                OFS_INT_MASK: int_mask_next   = hwdata[INT_BITS-1:0];
                default:      int_mask_next   = int_mask_reg;
            endcase
        end
        // An event in the clearing cycle survives the clear
        int_stat_next = int_stat_next | int_set;

        if (rd_pend_reg) begin
            case (addr_reg)
                OFS_STATUS:    rdata_next = {28'h0, (state_reg != LS_UNALIGNED),
                                             ~ref_en_reg, otr_reg,
                                             (state_reg == LS_RUNNING)};
                OFS_INT_STAT:  rdata_next = {29'h0, int_stat_reg};
                OFS_INT_MASK:  rdata_next = {29'h0, int_mask_reg};
                OFS_LAST_WORD: rdata_next = {16'h0, last_word_reg};
                default:       rdata_next = 32'h0;
            endcase
        end

        // Address phase is accepted only when no read is still waiting
        if (take && !rd_pend_reg) begin
            addr_next    = {haddr[7:2], 2'h0};
            wr_pend_next = hwrite;
            rd_pend_next = ~hwrite;
        end else if (rd_pend_reg) begin
            rd_pend_next = 1'b0;
        end
    end

    // Bus registers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            wr_pend_reg    <= 1'b0;
            rd_pend_reg    <= 1'b0;
            addr_reg       <= 8'h00;
            rdata_reg      <= 32'h0000_0000;
            int_stat_reg   <= 3'h0;
            int_mask_reg   <= INT_MASK_RST;
            soft_align_reg <= 1'b0;
        end else begin
            wr_pend_reg    <= wr_pend_next;
            rd_pend_reg    <= rd_pend_next;
            addr_reg       <= addr_next;
            rdata_reg      <= rdata_next;
            int_stat_reg   <= int_stat_next;
            int_mask_reg   <= int_mask_next;
            soft_align_reg <= soft_align_next;
        end
    end

    // Bus answers and interrupt level
    assign hrdata    = rdata_reg;
    assign hreadyout = ~rd_pend_reg;
    assign hresp     = 1'b0;
    assign irq       = |(int_stat_reg & int_mask_reg);

endmodule
`default_nettype wire

/* aos_pkg.sv */
// Package of constants and types for the converter serial output block
package aos_pkg;
    // Word format and decimation
    localparam int          WORD_BITS    = 16;
    localparam int          RAW_BITS     = 18;
    localparam logic [3:0]  DECIM_LAST   = 4'hF;          // 16 samples per word
    localparam logic [5:0]  SETTLE_WORDS = 6'h33;         // 51 word periods
    localparam logic [15:0] POS_FULL     = 16'h7FFF;
    localparam logic [15:0] NEG_FULL     = 16'h8000;

    // Register byte offsets
    localparam logic [7:0] OFS_CTRL      = 8'h00;
    localparam logic [7:0] OFS_STATUS    = 8'h04;
    localparam logic [7:0] OFS_INT_STAT  = 8'h08;
    localparam logic [7:0] OFS_INT_MASK  = 8'h0C;
    localparam logic [7:0] OFS_LAST_WORD = 8'h10;

    // Field positions
    localparam int CTRL_SOFT_ALIGN = 0;
    localparam int ST_RUNNING      = 0;
    localparam int ST_OVERRANGE    = 1;
    localparam int ST_EXT_REF      = 2;
    localparam int ST_ALIGNED      = 3;
    localparam int INT_WORD        = 0;
    localparam int INT_OVER        = 1;
    localparam int INT_SETTLED     = 2;
    localparam int INT_BITS        = 3;

    // Reset values
    localparam logic [2:0]  INT_MASK_RST = 3'h0;
    localparam logic [15:0] WORD_RST     = 16'h0000;

    // AHB encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] HTRANS_SEQ    = 2'h3;

    // Link sequencing states
    typedef enum logic [1:0] {
        LS_UNALIGNED = 2'b00,
        LS_ALIGNING  = 2'b01,
        LS_SETTLING  = 2'b10,
        LS_RUNNING   = 2'b11
    } aos_state_type;
endpackage

/* aos_link_receiver.sv */
// Receiver model for the far end of the serial link
`timescale 1ns/100ps
`default_nettype none
module aos_link_receiver (
    // Link from the block, which owns both clock and frame
    input  wire logic rstn,
    input  wire logic frame_start_out,
    input  wire logic serial_shift_clock,
    input  wire logic serial_data_out,
    // Captured words
    output logic [15:0] rx_word,
    output int          rx_count
);
    logic [15:0] shift;
    int          bits;

    // Sample on the falling shift clock, half a bit after data moves
    always @(negedge serial_shift_clock or negedge rstn) begin
        if (!rstn) begin
            bits = 0;
            rx_count = 0;
            rx_word = 16'h0000;
        end else begin
            if (frame_start_out) begin
                bits = 0;
            end
            if (frame_start_out || bits > 0) begin
                shift = {shift[14:0], serial_data_out};
                bits++;
            end
            if (bits == 16) begin // Whole word, MSB arrived first
                rx_word = shift;
                rx_count++;
                bits = 0;
            end
        end
    end
endmodule
`default_nettype wire

/* aos_serial_out_asserts.sv */
// Port-level checks for the converter serial output block
`timescale 1ns/100ps
`default_nettype none
module aos_serial_out_asserts (
    // System
    input wire logic       clk,
    input wire logic       rstn,
    // Converter pins
    input wire logic       align_pulse,
    input wire logic       power_down_n,
    input wire logic       internal_reference_select,
    input wire logic       ref_gen_enable,
    // Link
    input wire logic       frame_start_out,
    input wire logic       frame_start_out_n,
    input wire logic       serial_shift_clock,
    input wire logic       serial_shift_clock_n,
    input wire logic       serial_data_out,
    input wire logic       serial_data_out_n,
    input wire logic       overrange_flag,
    // Bus
    input wire logic       hsel,
    input wire logic [1:0] htrans,
    input wire logic       hwrite,
    input wire logic       hready,
    input wire logic       hreadyout
);
    logic       sclk_d_reg, frame_d_reg;
    logic [9:0] gap_reg, gap_next, quiet_reg, quiet_next;

    // Shift clock rises since last frame, and since last align or power-down
    always_comb begin
        gap_next = gap_reg;
        quiet_next = quiet_reg;
        if (serial_shift_clock && !sclk_d_reg) begin // Counters saturate, never wrap
            if (gap_reg != 10'h3FF) gap_next = gap_reg + 10'h001;
            if (quiet_reg != 10'h3FF) quiet_next = quiet_reg + 10'h001;
        end
        if (frame_start_out && !frame_d_reg) gap_next = 10'h000;
        if (align_pulse || !power_down_n) quiet_next = 10'h000;
    end

    // Register the helpers
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            sclk_d_reg <= 1'b0;
            frame_d_reg <= 1'b0;
            gap_reg <= 10'h3FF;
            quiet_reg <= 10'h000;
        end else begin
            sclk_d_reg <= serial_shift_clock;
            frame_d_reg <= frame_start_out;
            gap_reg <= gap_next;
            quiet_reg <= quiet_next;
        end
    end

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rstn);

    a_link_companions: assert property (frame_start_out_n == !frame_start_out
        && serial_shift_clock_n == !serial_shift_clock && serial_data_out_n == !serial_data_out)
        else $error("companion output not inverse");
    a_flag_on_fall: assert property ($changed(overrange_flag)
        |-> $fell(serial_shift_clock))
        else $error("overrange flag moved off a falling shift clock");
    a_frame_first_bit: assert property ($rose(frame_start_out)
        |-> $rose(serial_shift_clock))
        else $error("frame start not on a bit boundary");
    a_frame_one_bit: assert property ($fell(frame_start_out)
        |-> $rose(serial_shift_clock))
        else $error("frame start not one bit long");
    a_word_spacing: assert property ($rose(frame_start_out) && gap_reg < 10'h020
        |-> gap_reg == 10'h00F) else $error("frames not 16 bits apart");
    a_settle_hold: assert property ($rose(frame_start_out)
        |-> quiet_reg >= 10'h32A)
        else $error("frame before filter settled");
    a_ref_follows: assert property ($changed(internal_reference_select)
        |-> ##4 ref_gen_enable == !internal_reference_select)
        else $error("reference enable wrong");
    a_read_wait: assert property (hsel && hready && htrans[1] && !hwrite
        |=> !hreadyout ##1 hreadyout) else $error("read wait state wrong");
    a_write_nowait: assert property (hsel && hready && htrans[1] && hwrite |=> hreadyout)
        else $error("write stalled");

    c_frame: cover property ($rose(frame_start_out));
    c_over: cover property ($rose(overrange_flag));
    c_read: cover property (hsel && hready && htrans[1] && !hwrite);
    c_ext_ref: cover property ($fell(ref_gen_enable));
endmodule

bind aos_serial_out aos_serial_out_asserts aos_serial_out_asserts_inst (
    .clk(clk), .rstn(rstn), .align_pulse(align_pulse), .power_down_n(power_down_n),
    .internal_reference_select(internal_reference_select), .ref_gen_enable(ref_gen_enable),
    .frame_start_out(frame_start_out), .frame_start_out_n(frame_start_out_n),
    .serial_shift_clock(serial_shift_clock), .serial_shift_clock_n(serial_shift_clock_n),
    .serial_data_out(serial_data_out), .serial_data_out_n(serial_data_out_n),
    .overrange_flag(overrange_flag), .hsel(hsel), .htrans(htrans), .hwrite(hwrite),
    .hready(hready), .hreadyout(hreadyout)
);
`default_nettype wire

/* test_aos_serial_out.sv */
// Self-checking bench for the converter serial output block
`timescale 1ns/100ps
`default_nettype none
module test_aos_serial_out
    import aos_pkg::*;
;
    // Design pins
    logic                clk, rstn, conv_clock, align_pulse, power_down_n, irq;
    logic                internal_reference_select, ref_gen_enable, overrange_flag;
    logic                frame_start_out, serial_shift_clock, serial_data_out;
    logic [RAW_BITS-1:0] filter_result;
    logic                hsel, hwrite, hreadyout, hresp;
    logic [1:0]          htrans;
    logic [2:0]          hsize;
    logic [31:0]         haddr, hwdata, hrdata, rd;
    // Receiver and bookkeeping
    logic [15:0]         rx_word;
    int                  rx_count, fail_count, checks_done, n;
    // Results around both clip points and zero
    logic [17:0]         vals [10] = '{18'h00000, 18'h00001, 18'h3FFFF, 18'h07FFF, 18'h08000,
                                       18'h1FFFF, 18'h38000, 18'h37FFF, 18'h20000, 18'h01234};

    aos_serial_out aos_serial_out_inst (
        .clk(clk), .rstn(rstn), .conv_clock(conv_clock), .align_pulse(align_pulse),
        .power_down_n(power_down_n), .internal_reference_select(internal_reference_select),
        .filter_result(filter_result), .ref_gen_enable(ref_gen_enable),
        .frame_start_out(frame_start_out), .frame_start_out_n(),
        .serial_shift_clock(serial_shift_clock), .serial_shift_clock_n(),
        .serial_data_out(serial_data_out), .serial_data_out_n(),
        .overrange_flag(overrange_flag), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .irq(irq));

    aos_link_receiver aos_link_receiver_inst (.rstn(rstn), .frame_start_out(frame_start_out),
        .serial_shift_clock(serial_shift_clock), .serial_data_out(serial_data_out),
        .rx_word(rx_word), .rx_count(rx_count));

    // System clock
    initial clk = 1'b0;
    always #5 clk = ~clk;

    // Converter clock with an odd offset, so no phase to clk is assumed
    initial begin
        conv_clock = 1'b0;
        #3;
        forever #40 conv_clock = ~conv_clock;
    end

    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", checks_done, fail_count);
        if (fail_count == 0 && checks_done > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            $display("wrong value %s expected %h seen %h", what, exp, seen);
            fail_count++;
        end
    endtask

    // A wait that runs out is a mismatch
    task automatic give_up(input int k, input int lim);
        if (k >= lim) begin
            fail_count++;
            report_and_stop();
        end
    endtask

    // One single AHB transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        hsel <= 1'b1;
        haddr <= {24'h000000, a};
        hwrite <= wr;
        htrans <= HTRANS_NONSEQ;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        htrans <= 2'h0;
        hsel <= 1'b0;
        hwdata <= d;
        do begin @(posedge clk); k++; end while (hreadyout !== 1'b1 && k < 50);
        rd = hrdata;
        check("response", {31'h0, hresp}, 32'h0);
        give_up(k, 50);
    endtask

    // Cycles until the next rising frame start
    task automatic wait_frame(input int lim);
        n = 0;
        while (frame_start_out === 1'b1 && n < lim) begin @(posedge clk); n++; end
        while (frame_start_out !== 1'b1 && n < lim) begin @(posedge clk); n++; end
        give_up(n, lim);
    endtask

    task automatic wait_rx();
        int c, k;
        c = rx_count;
        k = 0;
        while (rx_count == c && k < 300) begin @(posedge clk); k++; end
        give_up(k, 300);
    endtask

    // First frame must not come before 50 word periods of 128 clk
    task automatic settle();
        wait_frame(8000);
        check("settle time", n >= 6400, 1'b1);
    endtask

    function automatic logic [15:0] clip(input logic [17:0] v);
        if ($signed(v) > 32767) return POS_FULL;
        if ($signed(v) < -32768) return NEG_FULL;
        return v[15:0];
    endfunction

    // Main sequence
    initial begin
        rstn = 1'b0; align_pulse = 1'b0; power_down_n = 1'b1; internal_reference_select = 1'b0;
        filter_result = '0; hsel = 1'b0; haddr = '0; htrans = 2'h0; hwrite = 1'b0;
        hsize = 3'h2; hwdata = '0; fail_count = 0; checks_done = 0;
        repeat (4) @(posedge clk);
        rstn <= 1'b1;
        @(posedge clk);
        bus(0, OFS_INT_MASK, 0);
        check("mask reset", rd, 32'h0);
        bus(0, 8'h20, 0);
        check("unmapped", rd, 32'h0);
        internal_reference_select <= 1'b1;
        repeat (10) @(posedge clk);
        check("ref off", ref_gen_enable, 1'b0);
        bus(0, OFS_STATUS, 0);
        check("status ext", rd, 32'h4);
        internal_reference_select <= 1'b0;
        repeat (300) @(posedge clk);
        check("ref on", ref_gen_enable, 1'b1);
        check("unaligned frames", rx_count, 0);
        // Align pulse of two converter clocks, launched after a falling edge
        @(negedge conv_clock);
        @(posedge clk);
        align_pulse <= 1'b1;
        repeat (16) @(posedge clk);
        align_pulse <= 1'b0;
        settle();
        wait_rx();
        bus(0, OFS_STATUS, 0);
        check("status run", rd, 32'h9);
        bus(0, OFS_INT_STAT, 0);
        check("events", rd & 32'h5, 32'h5);
        bus(1, OFS_INT_MASK, 32'h4);
        repeat (2) @(posedge clk);
        check("irq up", irq, 1'b1);
        bus(1, OFS_INT_STAT, 32'h4);
        repeat (2) @(posedge clk);
        check("irq down", irq, 1'b0);
        bus(1, OFS_INT_MASK, 32'h0);
        // Each frame carries the result set while the previous frame began
        for (int i = 0; i <= 10; i++) begin
            wait_frame(300);
            if (i < 10) filter_result <= vals[i];
            wait_rx();
            if (i > 0) begin
                check("word", rx_word, clip(vals[i-1]));
                check("flag", overrange_flag, clip(vals[i-1]) != vals[i-1][15:0]);
            end
        end
        bus(0, OFS_INT_STAT, 0);
        check("over event", rd & 32'h2, 32'h2);
        wait_rx();
        bus(0, OFS_LAST_WORD, 0);
        check("last word", rd, {16'h0000, clip(vals[9])});
        // Power-down stops frames; wait out the frame strobe so it is not cut short
        repeat (12) @(posedge clk);
        power_down_n <= 1'b0;
        repeat (200) @(posedge clk);
        n = rx_count;
        repeat (300) @(posedge clk);
        check("halted", rx_count, n);
        power_down_n <= 1'b1;
        settle();
        // Soft align restarts settling as the pin does; let the strobe end first
        repeat (12) @(posedge clk);
        bus(1, OFS_CTRL, 32'h1);
        settle();
        report_and_stop();
    end
endmodule
`default_nettype wire
